// ==== hw/adc_seq_pkg.sv ====
/*
 * Shared constants and types of the channel list sequencer: register
 * offsets, field positions, timing counts, list entry and multiplexer
 * command layouts.
 * Assumes a 100 MHz module clock and a 32-bit APB register bus.
 */
package adc_seq_pkg;

	// Module clock
	localparam int CLK_PERIOD_NS = 10;

	// Times as given and their cycle counts (least times round up)
	localparam int SETTLE_NS = 2500;
	localparam int CONV_NS   = 2500;
	localparam int CLEAR_NS  = 10000;
	localparam int SETTLE_CYC =
		(SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CYC =
		(CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_CYC =
		(CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 10;

	// Register byte addresses
	localparam logic [7:0] CTRL_ADDR   = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] LIST_ADDR   = 8'h08;

	// Control and status field positions
	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int STAT_ENABLE_BIT  = 0;
	localparam int STAT_CLEAR_BIT   = 1;
	localparam int STAT_DONE_BIT    = 2;
	localparam int STAT_COUNT_LSB   = 16;
	localparam logic CTRL_RESET     = 1'b0;

	// List entry field codes
	localparam int ENTRY_W = 14;
	localparam logic [1:0] TEST_ANALOGUE_OUTPUT_ZERO   = 2'h0;
	localparam logic [1:0] TEST_ANALOGUE_OUTPUT_ONE   = 2'h1;
	localparam logic [1:0] TEST_GROUND = 2'h3;

	typedef struct packed {
		logic [2:0] gain;
		logic [3:0] reserved;
		logic       sub_frame_start_marker;
		logic [5:0] channel;
	} list_entry_type;

	// Source routed through the multiplexer
	typedef enum logic [3:0] {
		SRC_INPUT  = 4'h1,
		SRC_ANALOGUE_OUTPUT_ZERO   = 4'h2,
		SRC_ANALOGUE_OUTPUT_ONE   = 4'h4,
		SRC_GROUND = 4'h8
	} source_type;

	typedef struct packed {
		source_type  source;
		logic [3:0]  input_index;
		logic [7:0]  gain_select;
	} mux_command_type;

endpackage

// ==== hw/adc_channel_list_sequencer.sv ====
/*
 * Channel list sequencer for a simultaneous-sampling analogue input path:
 * list store, sub-frame sequencing, converter timing and APB registers.
 * Assumes the sample tick, conversion done and data inputs are synchronous
 * to clk, and that an external result FIFO takes one word per push.
 */
`timescale 1ns/10ps
`default_nettype none

module adc_channel_list_sequencer #(
	parameter int LIST_DEPTH = 4096
) (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          sample_tick,
	output logic                               simultaneous_hold_channel,
	output adc_seq_pkg::mux_command_type       mux_command,
	output logic                               conv_start,
	input  wire logic                          conv_done,
	input  wire logic [adc_seq_pkg::ENTRY_W-1:0] conv_data,
	output logic                               result_push,
	output logic [adc_seq_pkg::ENTRY_W-1:0]    result_data,
	output logic                               result_fifo_reset,
	output logic                               list_done_event
);

	localparam int PTR_W = $clog2(LIST_DEPTH);
	localparam int CNT_W = $clog2(LIST_DEPTH + 1);

	// Count field of the status word holds at most 15 bits
	if (LIST_DEPTH < 2 || CNT_W > 15) begin : g_depth_check
		$error("LIST_DEPTH out of range");
	end

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_TICK   = 6'h02,
		ST_SETTLE = 6'h04,
		ST_CONV   = 6'h08,
		ST_DONE   = 6'h10,
		ST_CLEAR  = 6'h20
	} state_type;

	function automatic adc_seq_pkg::mux_command_type decode_entry(
		input adc_seq_pkg::list_entry_type e
	);
		adc_seq_pkg::mux_command_type c;
		c = '{source: adc_seq_pkg::SRC_GROUND, input_index: 4'h0,
			gain_select: 8'h00};
		c.gain_select = 8'h01 << e.gain;
		if (!e.channel[5] && e.channel[4] == 1'b0) begin
			c.source = adc_seq_pkg::SRC_INPUT;
			c.input_index = e.channel[3:0];
		end else if (e.channel[5] && e.channel[3:2] == 2'h0) begin
			unique case (e.channel[1:0])
				adc_seq_pkg::TEST_ANALOGUE_OUTPUT_ZERO:   c.source = adc_seq_pkg::SRC_ANALOGUE_OUTPUT_ZERO;
				adc_seq_pkg::TEST_ANALOGUE_OUTPUT_ONE:   c.source = adc_seq_pkg::SRC_ANALOGUE_OUTPUT_ONE;
				default:                  c.source = adc_seq_pkg::SRC_GROUND;
			endcase
		end
		return c;
	endfunction

	logic [adc_seq_pkg::ENTRY_W-1:0] list_mem [LIST_DEPTH];
	state_type                  state_r, state_nxt;
	logic [PTR_W-1:0]           ptr_r;
	logic [CNT_W-1:0]           count_r;
	logic [adc_seq_pkg::TMR_W-1:0] tmr_r;
	logic                       got_r;
	logic                       enable_r;
	logic                       done_flag_r;
	logic                       pready_r;
	logic                       pslverr_r;
	logic [31:0]                prdata_r;
	logic                       hold_r;
	logic                       start_r;
	logic                       push_r;
	logic [adc_seq_pkg::ENTRY_W-1:0] result_r;
	logic                       fifo_rst_r;
	logic                       done_evt_r;
	adc_seq_pkg::mux_command_type cmd_r;

	// APB decode
	wire logic acc_first = psel & penable & ~pready_r;
	wire logic acc_fire  = psel & penable & pready_r;
	wire logic hit_ctrl  = paddr == adc_seq_pkg::CTRL_ADDR;
	wire logic hit_stat  = paddr == adc_seq_pkg::STATUS_ADDR;
	wire logic hit_list  = paddr == adc_seq_pkg::LIST_ADDR;
	wire logic list_full = count_r == CNT_W'(LIST_DEPTH);
	wire logic clearing  = state_r == ST_CLEAR;
	wire logic bad_acc   = ~(hit_ctrl | hit_stat | hit_list)
		| (hit_list & (~pwrite | list_full | clearing));
	wire logic wr_fire   = acc_fire & pwrite & ~pslverr_r;
	wire logic wr_ctrl   = wr_fire & hit_ctrl;
	wire logic wr_stat   = wr_fire & hit_stat;
	wire logic wr_list   = wr_fire & hit_list;
	wire logic new_enable = wr_ctrl ? pwdata[adc_seq_pkg::CTRL_ENABLE_BIT]
		: enable_r;
	wire logic enable_fall = enable_r & ~new_enable;
	wire logic [31:0] stat_word = {
		{(16 - CNT_W){1'b0}}, count_r, 13'h0000, done_flag_r,
		clearing, enable_r};
	wire logic [31:0] rd_word = hit_stat ? stat_word : 32'h0000_0000;

	// Sequencing
	wire adc_seq_pkg::list_entry_type cur_entry = list_mem[ptr_r];
	wire logic [PTR_W-1:0] ptr_inc = ptr_r + PTR_W'(1);
	// Compared at count width so a full list still wraps
	wire logic wrap       =
		(CNT_W'(ptr_r) + CNT_W'(1)) >= count_r;
	wire logic [PTR_W-1:0] ptr_next = wrap ? '0 : ptr_inc;
	wire adc_seq_pkg::list_entry_type next_entry = list_mem[ptr_next];
	wire logic done_now   = got_r | conv_done;
	wire logic step       = state_r == ST_DONE && done_now && tmr_r == '0;
	wire logic tmr_zero   = tmr_r == '0;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:
				if (enable_r && count_r != '0)
					state_nxt = ST_TICK;
			ST_TICK:
				if (sample_tick)
					state_nxt = ST_SETTLE;
			ST_SETTLE:
				if (tmr_zero)
					state_nxt = ST_CONV;
			ST_CONV:
				state_nxt = ST_DONE;
			ST_DONE:
				if (step)
					state_nxt = next_entry.sub_frame_start_marker
						? ST_TICK : ST_CONV;
			ST_CLEAR:
				if (tmr_zero)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
		if (enable_fall)
			state_nxt = ST_CLEAR;
	end

	// Register bus
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			enable_r  <= adc_seq_pkg::CTRL_RESET;
		end else if (ce) begin
			pready_r  <= acc_first;
			pslverr_r <= acc_first & bad_acc;
			prdata_r  <= acc_first ? rd_word : 32'h0000_0000;
			enable_r  <= new_enable;
		end
	end

	// List store
	always_ff @(posedge clk) begin
		if (ce && wr_list)
			list_mem[PTR_W'(count_r)] <=
				pwdata[adc_seq_pkg::ENTRY_W-1:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r     <= '0;
			done_flag_r <= 1'b0;
		end else if (ce) begin
			if (state_nxt == ST_CLEAR)
				count_r <= '0;
			else if (wr_list)
				count_r <= count_r + CNT_W'(1);
			if (step && wrap)
				done_flag_r <= 1'b1;
			else if (wr_stat && !pwdata[adc_seq_pkg::STAT_DONE_BIT])
				done_flag_r <= 1'b0;
		end
	end

	// Sequencer state and timers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			ptr_r   <= '0;
			tmr_r   <= '0;
			got_r   <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			if (state_nxt == ST_CLEAR || state_r == ST_IDLE)
				ptr_r <= '0;
			else if (step)
				ptr_r <= ptr_next;
			if (enable_fall)
				tmr_r <= adc_seq_pkg::TMR_W'(adc_seq_pkg::CLEAR_CYC - 1);
			else if (state_r == ST_TICK && sample_tick)
				tmr_r <= adc_seq_pkg::TMR_W'(adc_seq_pkg::SETTLE_CYC - 2);
			else if (state_r == ST_CONV)
				tmr_r <= adc_seq_pkg::TMR_W'(adc_seq_pkg::CONV_CYC - 2);
			else if (!tmr_zero)
				tmr_r <= tmr_r - adc_seq_pkg::TMR_W'(1);
			if (state_r == ST_CONV)
				got_r <= 1'b0;
			else if (state_r == ST_DONE && conv_done)
				got_r <= 1'b1;
		end
	end

	// Analogue side outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_r     <= 1'b0;
			start_r    <= 1'b0;
			push_r     <= 1'b0;
			result_r   <= '0;
			fifo_rst_r <= 1'b0;
			done_evt_r <= 1'b0;
			cmd_r      <= '{source: adc_seq_pkg::SRC_GROUND,
				input_index: 4'h0, gain_select: 8'h01};
		end else if (ce) begin
			hold_r     <= state_r == ST_TICK && sample_tick;
			start_r    <= state_r == ST_CONV;
			push_r     <= state_r == ST_DONE && conv_done && !got_r;
			if (state_r == ST_DONE && conv_done && !got_r)
				result_r <= conv_data;
			fifo_rst_r <= state_nxt == ST_CLEAR;
			done_evt_r <= step && wrap;
			cmd_r      <= decode_entry(cur_entry);
		end
	end

	assign prdata                    = prdata_r;
	assign pready                    = pready_r;
	assign pslverr                   = pslverr_r;
	assign simultaneous_hold_channel = hold_r;
	assign mux_command               = cmd_r;
	assign conv_start                = start_r;
	assign result_push               = push_r;
	assign result_data               = result_r;
	assign result_fifo_reset         = fifo_rst_r;
	assign list_done_event           = done_evt_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [15:0] since_hold_r;
	logic [15:0] since_start_r;
	logic        started_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since_hold_r  <= 16'h0000;
			since_start_r <= 16'h0000;
			started_r     <= 1'b0;
		end else if (ce) begin
			since_hold_r  <= hold_r ? 16'h0001
				: (since_hold_r == 16'hFFFF ? since_hold_r
				: since_hold_r + 16'h0001);
			since_start_r <= start_r ? 16'h0001
				: (since_start_r == 16'hFFFF ? since_start_r
				: since_start_r + 16'h0001);
			started_r     <= started_r | start_r;
		end
	end

	hold_then_settle_a: assert property (
		start_r && $past(state_r) == ST_CONV && since_hold_r < 16'h03E8
		|-> since_hold_r >= 16'(adc_seq_pkg::SETTLE_CYC))
		else $error("conversion started before settling");
	conv_rate_a: assert property (
		start_r && started_r |-> since_start_r >= 16'(adc_seq_pkg::CONV_CYC))
		else $error("conversions closer than 2.5 us");
	hold_on_tick_a: assert property (
		ce && state_r == ST_TICK && sample_tick && !enable_fall
		|=> hold_r && state_r == ST_SETTLE)
		else $error("tick did not hold inputs");
	one_subframe_a: assert property (
		ce && state_r != ST_TICK |=> !hold_r)
		else $error("hold outside waiting for tick");
	result_push_a: assert property (
		ce && state_r == ST_DONE && conv_done && !got_r
		|=> result_push && result_data == $past(conv_data))
		else $error("converter result not pushed");
	wrap_done_a: assert property (
		list_done_event |-> ptr_r == '0 && done_flag_r)
		else $error("list end not wrapped or flagged");
	clear_reset_a: assert property (
		ce && enable_fall |=> result_fifo_reset && count_r == '0
		&& state_r == ST_CLEAR)
		else $error("enable fall did not clear list");
	gain_onehot_a: assert property (
		$onehot(mux_command.gain_select))
		else $error("gain select not one-hot");
	wrap_bound_a: assert property (
		state_r != ST_IDLE && state_r != ST_CLEAR
		|-> CNT_W'(ptr_r) < count_r)
		else $error("list pointer beyond written entries");
	subframe_wait_a: assert property (
		ce && step && next_entry.sub_frame_start_marker && !enable_fall
		|=> state_r == ST_TICK)
		else $error("sub-frame start did not wait for tick");
	list_refused_a: assert property (
		ce && acc_first && hit_list && clearing |=> pslverr)
		else $error("list write accepted during clear");

	full_pass_c: cover property (list_done_event);
	tick_conv_c: cover property (hold_r ##[1:300] conv_start);
	clear_c: cover property ($fell(result_fifo_reset));
	subframe_wait_c: cover property (
		step && next_entry.sub_frame_start_marker);
	list_refused_c: cover property (pslverr && hit_list);

endmodule

`default_nettype wire

// ==== tb/adc_converter_model.sv ====
/*
 * Converter stand-in: each start pulse is answered by one done pulse that
 * carries a running sample number.
 * Assumes start pulses on clk and no start while a conversion is busy.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_converter_model (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        slow,
	input  wire logic                        conv_start,
	output logic                             conv_done,
	output logic [adc_seq_pkg::ENTRY_W-1:0]  conv_data
);
	logic [8:0]                       cnt_r;
	logic                             busy_r;
	logic [adc_seq_pkg::ENTRY_W-1:0]  seq_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 9'h000;
			busy_r <= 1'b0;
			seq_r <= '0;
			conv_done <= 1'b0;
			conv_data <= '0;
		end else begin
			conv_done <= 1'b0;
			// Data line toggles every cycle outside the done cycle
			conv_data <= ~conv_data;
			if (conv_start && !busy_r) begin
				busy_r <= 1'b1;
				// Slow answers outlast the conversion slot
				cnt_r <= slow ? 9'h103 : 9'h002;
			end else if (busy_r && cnt_r != 9'h000) begin
				cnt_r <= cnt_r - 9'h001;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= seq_r;
				seq_r <= seq_r + 14'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/adc_channel_list_sequencer_tb.sv ====
/*
 * Testbench of the channel list sequencer: APB register access, list
 * scanning with timing checks, list-done flag and list clear.
 * Assumes the converter model and a 100 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_channel_list_sequencer_tb;
	logic                          clk, rst_n, ce, psel, penable, pwrite;
	logic                          sample_tick, slow, tick_on, tk;
	logic                          pready, pslverr, hold, cs, cd, push;
	logic                          frst, dev;
	logic [7:0]                    paddr;
	logic [31:0]                   pwdata, prdata;
	logic [13:0]                   cdata, rdata;
	adc_seq_pkg::mux_command_type  mux;
	logic [13:0]                   lst[$];
	int                            num_errors, checks_done, cyc, idx, subn;
	int                            ns_sub, npush, npass, ndone, hcyc, lcyc, rcnt;

	always #5 clk = ~clk;

	adc_channel_list_sequencer #(.LIST_DEPTH(16)) uut (.clk(clk),
		.rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
		.simultaneous_hold_channel(hold), .mux_command(mux),
		.conv_start(cs), .conv_done(cd), .conv_data(cdata),
		.result_push(push), .result_data(rdata),
		.result_fifo_reset(frst), .list_done_event(dev));

	adc_converter_model conv (.clk(clk), .rst_n(rst_n), .slow(slow),
		.conv_start(cs), .conv_done(cd), .conv_data(cdata));

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] er, input logic ee);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk);
		while (pready !== 1'b1);
		chk({30'h0, pready, pslverr}, {30'h0, 1'b1, ee});
		if (!w && !ee) chk(prdata, er);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function logic [13:0] ent(input logic f, input logic [5:0] c,
		input logic [2:0] g, input logic [3:0] r);
		return {g, r, f, c};
	endfunction

	// Expected source, one-hot gain and index of a list entry
	function logic [15:0] dec(input logic [13:0] e);
		logic [3:0] s;
		s = e[5] ? (e[3:0] == 4'h0 ? 4'h2 : e[3:0] == 4'h1 ? 4'h4 : 4'h8)
			: (e[4] ? 4'h8 : 4'h1);
		return {s, 8'h01 << e[13:11], s == 4'h1 ? e[3:0] : 4'h0};
	endfunction

	task load;
		idx = 0;
		ns_sub = 0;
		npass = 0;
		foreach (lst[i]) apb(1'b1, 8'h08, {18'h0, lst[i]}, 0, 1'b0);
	endtask

	task wait_done(input int k);
		while (ndone < k) @(posedge clk);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (hold) begin
			chk(tk, 1);
			if (ns_sub != 0) chk(ns_sub, subn);
			hcyc = cyc;
			ns_sub = 0;
		end
		if (cs) begin
			if (ns_sub == 0) chk(cyc - hcyc, 250);
			else chk(cyc - lcyc >= 250, 1);
			chk({16'h0, mux.source, mux.gain_select, mux.source === adc_seq_pkg::SRC_INPUT ? mux.input_index : 4'h0}, {16'h0, dec(lst[idx])});
			idx = (idx + 1) % lst.size();
			ns_sub++;
			lcyc = cyc;
		end
		if (push) begin
			chk({18'h0, rdata}, npush);
			npush++;
			npass++;
		end
		if (dev) begin
			chk(npass, lst.size());
			chk(idx, 0);
			npass = 0;
			ndone++;
		end
		if (frst) rcnt++;
		else if (rcnt != 0) begin
			chk(rcnt, 1000);
			rcnt = 0;
		end
		tk = sample_tick;
	end

	// Tick period keeps within the rate limit for four entries
	initial forever begin
		repeat (1499) @(posedge clk);
		sample_tick <= tick_on;
		@(posedge clk);
		sample_tick <= 1'b0;
	end

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		final_report;
	end

	initial begin
		{clk, rst_n, psel, penable, pwrite, sample_tick, slow, tick_on} = 0;
		{tk, paddr, pwdata} = 0;
		ce = 1'b1;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h04, 0, 32'h0, 1'b0);
		apb(1'b0, 8'h0C, 0, 0, 1'b1);
		apb(1'b0, 8'h08, 0, 0, 1'b1);
		$display("test registers done");
		lst = '{ent(1, 6'h01, 0, 0), ent(0, 6'h0F, 1, 4'hF),
			ent(0, 6'h20, 2, 0), ent(0, 6'h31, 3, 0), ent(1, 6'h23, 4, 0),
			ent(0, 6'h10, 5, 4'h5), ent(0, 6'h2A, 6, 0), ent(0, 6'h00, 7, 0)};
		subn = 4;
		load;
		apb(1'b0, 8'h04, 0, 32'h0008_0000, 1'b0);
		tick_on <= 1'b1;
		apb(1'b1, 8'h00, 32'h1, 0, 1'b0);
		wait_done(1);
		apb(1'b0, 8'h04, 0, 32'h0008_0005, 1'b0);
		apb(1'b1, 8'h04, 32'hFFFF_FFFB, 0, 1'b0);
		apb(1'b0, 8'h04, 0, 32'h0008_0001, 1'b0);
		slow <= 1'b1;
		wait_done(2);
		tick_on <= 1'b0;
		$display("test scan done");
		apb(1'b1, 8'h00, 32'h0, 0, 1'b0);
		apb(1'b1, 8'h08, 32'h41, 0, 1'b1);
		apb(1'b0, 8'h04, 0, 32'h0000_0006, 1'b0);
		while (frst !== 1'b0) @(posedge clk);
		repeat (2) @(posedge clk);
		$display("test clear done");
		lst = '{ent(1, 6'h02, 1, 0), ent(0, 6'h03, 3, 0), ent(0, 6'h23, 4, 0)};
		subn = 3;
		load;
		apb(1'b0, 8'h04, 0, 32'h0003_0004, 1'b0);
		tick_on <= 1'b1;
		apb(1'b1, 8'h00, 32'h1, 0, 1'b0);
		wait_done(3);
		$display("test relist done");
		final_report;
	end
endmodule
`default_nettype wire
